/* File: design/local_bus_bridge_config_port.sv */
// What this block does
// - Strap low makes the port a bridging master; high makes it a slave.
// - Strap low gives separate strobes; high gives read/write select and strobe.
// - Bridge writes drive data, reads sample data, on bridge clock rises.
// - Lanes follow byte enables and width bit; high enable marks upper lanes.
// - Configuring host uses only 16-bit words; no byte addressing.
// - Bridge drives address during a transfer and floats it otherwise.
// - Configuration mode decodes only the low sixteen address lines.
// - Write pin marks writes, or selects direction in the other style.
// - Read pin marks reads, or is the data strobe in the other style.
// - With arbitration on, strobes float outside transfers; else always driven in bridge mode, floating in configuration mode.
// - Unmasked low local interrupt sampled on bridge clock raises host interrupt.
// - Configuration mode pulls interrupt low while unmasked source is active.
// - Ready sampled on bridge clock only during transfers; ignored otherwise.
// - Grant sampled on bridge clock; polarity follows the strobe style.
// - Request asserted while seeking the bus, released with grant acknowledge.
// - Grant acknowledge held 32 shl timer bridge clocks after grant.
// - Bridge clock toggles on each enabled system clock, so half its rate; floats or can be disabled.
// - Configuration access accepted only with chip select low.
`timescale 1ns/1ps
`default_nettype none
`include "lbus_regs.svh"

module local_bus_bridge_config_port
    import lbus_pkg::*;
#(
    parameter int MEM_WORDS = 16
) (
    // System.
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Straps.
    input wire logic bus_role_select,
    input wire logic strobe_convention_select,
    // Local data and address.
    input wire logic [15:0] local_data_bus_i,
    output logic [15:0] local_data_bus_o,
    output logic local_data_bus_oe_n,
    input wire logic [19:0] local_address_bus_i,
    output logic [19:0] local_address_bus_o,
    output logic local_address_bus_oe_n,
    // Strobes.
    input wire logic write_strobe_i,
    output logic write_strobe_o,
    output logic write_strobe_oe_n,
    input wire logic read_strobe_n_i,
    output logic read_strobe_n_o,
    output logic read_strobe_oe_n,
    output logic high_byte_enable_n,
    output logic high_byte_enable_oe_n,
    // Interrupt, ready and arbitration.
    input wire logic bus_interrupt_n_i,
    output logic bus_interrupt_n_o,
    output logic bus_interrupt_oe_n,
    input wire logic bridge_ready_in_n,
    input wire logic bus_grant_in,
    output logic bus_request_out,
    output logic bus_request_oe_n,
    output logic grant_acknowledge_out_n,
    output logic grant_acknowledge_oe_n,
    // Bridge clock and chip select.
    output logic bridge_clock_out,
    output logic bridge_clock_oe_n,
    input wire logic host_chip_select_n,
    // Host side.
    output logic host_interrupt_a_n
);

    localparam int AW = $clog2(MEM_WORDS);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    pin_in_t pin_raw;
    pin_in_t pin_s1_q;
    pin_in_t pin_s2_q;

    assign pin_raw = {bus_role_select, strobe_convention_select,
                      host_chip_select_n, read_strobe_n_i, write_strobe_i,
                      bridge_ready_in_n, bus_grant_in, bus_interrupt_n_i,
                      local_address_bus_i, local_data_bus_i};

    always_ff @(posedge clk) begin
        if (ce) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode and bridge clock phase.

    ctrl_t ctrl_q;
    logic ph_q;
    wire logic role = pin_s2_q.role;
    wire logic conv = pin_s2_q.conv;
    wire logic bridge = !role;
    wire logic bridge_clock_out_rise = ce && !ph_q;
    wire logic grant_act = conv ? !pin_s2_q.grant : pin_s2_q.grant;

    always_ff @(posedge clk) begin
        if (rst) begin
            ph_q <= 1'b0;
        end else if (ce) begin
            ph_q <= !ph_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register access.

    logic ack_q;
    logic go_q;
    logic done_q;
    logic [19:0] xaddr_q;
    logic [15:0] xwdata_q;
    logic [15:0] xrdata_q;
    logic [3:0] be_n_q;
    logic dir_wr_q;
    logic bus_interrupt_q;
    logic gack_q;
    logic req_q;
    logic [15:0] mem_q [MEM_WORDS];
    bridge_state_t state_q;
    bridge_state_t state_d;

    wire logic wb_req = ce && wb_cyc_i && wb_stb_i && !ack_q;
    wire logic wb_wr = wb_req && wb_we_i;
    wire logic win_sel = wb_adr_i[`MEM_WIN_BIT];
    wire logic [7:0] reg_adr = {wb_adr_i[7:2], 2'b00};
    wire logic wr_ctrl = wb_wr && !win_sel && reg_adr == `OFF_CTRL;
    wire logic wr_stat = wb_wr && !win_sel && reg_adr == `OFF_STATUS;
    wire logic wr_xaddr = wb_wr && !win_sel && reg_adr == `OFF_XADDR;
    wire logic wr_xdata = wb_wr && !win_sel && reg_adr == `OFF_XDATA;
    wire logic wr_xcmd = wb_wr && !win_sel && reg_adr == `OFF_XCMD;
    wire logic [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wmerge_ctrl = (32'(ctrl_q) & ~wmask)
                                  | (wb_dat_i & wmask);
    wire logic start = wr_xcmd && bridge && state_q == ST_IDLE && !go_q;
    wire logic done_set = bridge_clock_out_rise && state_q == ST_XFER
                       && !pin_s2_q.rdy_n;
    wire logic done_clr = wr_stat && wb_dat_i[`STATUS_DONE_BIT];

    status_t status;
    assign status = '{pad: '0, grant_ack: gack_q, bus_interrupt: bus_interrupt_q,
                      done: done_q, busy: state_q != ST_IDLE || go_q,
                      conv: conv, role: role};

    wire logic [AW-1:0] win_idx = wb_adr_i[AW+1:2];
    wire logic [31:0] rd_word =
        win_sel ? {16'h0, mem_q[win_idx]} :
        reg_adr == `OFF_CTRL ? 32'(ctrl_q) :
        reg_adr == `OFF_STATUS ? 32'(status) :
        reg_adr == `OFF_XADDR ? {12'h0, xaddr_q} :
        reg_adr == `OFF_XDATA ? {16'h0, xrdata_q} :
        reg_adr == `OFF_XCMD ? {24'h0, be_n_q, 3'h0, dir_wr_q} : 32'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            wb_dat_o <= 32'h0;
            ctrl_q <= ctrl_t'(`CTRL_RESET);
            xaddr_q <= 20'h0;
            xwdata_q <= 16'h0;
            be_n_q <= `XCMD_RESET;
            dir_wr_q <= 1'b0;
            go_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            ack_q <= wb_req;
            wb_dat_o <= wb_req ? rd_word : 32'h0;
            if (wr_ctrl) begin
                ctrl_q <= ctrl_t'(wmerge_ctrl[10:0]);
            end
            if (wr_xaddr) begin
                xaddr_q <= wb_dat_i[19:0];
            end
            if (wr_xdata) begin
                xwdata_q <= wb_dat_i[15:0];
            end
            if (start) begin
                dir_wr_q <= wb_dat_i[`XCMD_WRITE_BIT];
                be_n_q <= wb_dat_i[`XCMD_BE_MSB:`XCMD_BE_LSB];
            end
            go_q <= start || (go_q && state_d == ST_IDLE);
            // A completion in the clearing cycle keeps the flag set.
            done_q <= done_set || (done_q && !done_clr);
        end
    end

    assign wb_ack_o = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // Bridge transfer sequencer.

    logic [19:0] arb_cnt_q;
    wire logic [20:0] arb_span = 21'h1 << (`ARB_BASE_LOG2
                                           + {1'b0, ctrl_q.arb_timer});
    wire logic [19:0] arb_load = 20'(arb_span - 21'h1);
    wire logic lo_used_raw = !be_n_q[0] || !be_n_q[2];
    wire logic hi_used = ctrl_q.width16
                      && (!be_n_q[1] || !be_n_q[3]);
    wire logic lo_used = lo_used_raw || !hi_used;
    wire logic [15:0] lane_mask = {{8{hi_used}}, {8{lo_used}}};
    wire logic xfer_d = bridge && state_d == ST_XFER;

    always_comb begin
        state_d = state_q;
        if (bridge_clock_out_rise) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (go_q && bridge) begin
                        state_d = ctrl_q.arb_en ? ST_REQ : ST_XFER;
                    end
                end
                ST_REQ: begin
                    if (grant_act) begin
                        state_d = ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (!pin_s2_q.rdy_n) begin
                        state_d = (gack_q && arb_cnt_q != 20'h0)
                                ? ST_HOLD : ST_IDLE;
                    end
                end
                ST_HOLD: begin
                    if (arb_cnt_q == 20'h0) begin
                        state_d = ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            arb_cnt_q <= 20'h0;
            gack_q <= 1'b0;
            req_q <= 1'b0;
            xrdata_q <= 16'h0;
            bus_interrupt_q <= 1'b0;
        end else if (bridge_clock_out_rise) begin
            state_q <= state_d;
            if (state_q == ST_REQ && grant_act) begin
                arb_cnt_q <= arb_load;
            end else if (arb_cnt_q != 20'h0) begin
                arb_cnt_q <= arb_cnt_q - 20'h1;
            end
            gack_q <= (state_q == ST_REQ && grant_act)
                   || (gack_q && state_d != ST_IDLE);
            req_q <= (state_d == ST_REQ)
                  || (req_q && state_d != ST_IDLE);
            if (done_set && !dir_wr_q) begin
                xrdata_q <= pin_s2_q.data & lane_mask;
            end
            bus_interrupt_q <= bridge && !pin_s2_q.int_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration slave.

    logic cfg_wr_q;
    logic [AW-1:0] cfg_idx_q;
    logic cfg_hit_q;
    logic [15:0] cfg_wdat_q;
    logic [15:0] cfg_rdata_q;
    wire logic cfg_sel = role && !pin_s2_q.cs_n;
    wire logic cfg_rd = cfg_sel && (conv ? !pin_s2_q.rd_n && pin_s2_q.wr
                                         : !pin_s2_q.rd_n);
    wire logic cfg_wr = cfg_sel && (conv ? !pin_s2_q.rd_n && !pin_s2_q.wr
                                         : !pin_s2_q.wr);
    wire logic [15:0] cfg_adr = pin_s2_q.addr[`CFG_DECODE_W-1:0];
    wire logic cfg_hit = cfg_adr[15:AW] == '0;
    wire logic cfg_commit = cfg_wr_q && !cfg_wr;

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_wr_q <= 1'b0;
            cfg_idx_q <= '0;
            cfg_hit_q <= 1'b0;
            cfg_wdat_q <= 16'h0;
            cfg_rdata_q <= 16'h0;
        end else if (ce) begin
            cfg_wr_q <= cfg_wr;
            if (cfg_wr) begin
                cfg_idx_q <= cfg_adr[AW-1:0];
                cfg_hit_q <= cfg_hit;
                cfg_wdat_q <= pin_s2_q.data;
            end
            cfg_rdata_q <= cfg_hit ? mem_q[cfg_adr[AW-1:0]] : 16'h0;
        end
    end

    // Whole words are stored when the write strobe ends.
    always_ff @(posedge clk) begin
        if (ce && cfg_commit && cfg_hit_q) begin
            mem_q[cfg_idx_q] <= cfg_wdat_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    wire logic strobe_drv = bridge && (!ctrl_q.arb_en || xfer_d);
    wire logic data_drv = bridge ? xfer_d && dir_wr_q : cfg_rd;

    always_ff @(posedge clk) begin
        if (rst) begin
            local_data_bus_o <= 16'h0;
            local_data_bus_oe_n <= 1'b1;
            local_address_bus_o <= 20'h0;
            local_address_bus_oe_n <= 1'b1;
            write_strobe_o <= 1'b1;
            write_strobe_oe_n <= 1'b1;
            read_strobe_n_o <= 1'b1;
            read_strobe_oe_n <= 1'b1;
            high_byte_enable_n <= 1'b1;
            high_byte_enable_oe_n <= 1'b1;
            bus_interrupt_n_o <= 1'b0;
            bus_interrupt_oe_n <= 1'b1;
            bus_request_out <= 1'b0;
            bus_request_oe_n <= 1'b1;
            grant_acknowledge_out_n <= 1'b1;
            grant_acknowledge_oe_n <= 1'b1;
            bridge_clock_out <= 1'b0;
            bridge_clock_oe_n <= 1'b1;
            host_interrupt_a_n <= 1'b1;
        end else if (ce) begin
            local_data_bus_o <= bridge ? xwdata_q : cfg_rdata_q;
            local_data_bus_oe_n <= !data_drv;
            local_address_bus_o <= xaddr_q;
            local_address_bus_oe_n <= !xfer_d;
            write_strobe_o <= conv ? !dir_wr_q
                                   : !(xfer_d && dir_wr_q);
            write_strobe_oe_n <= !strobe_drv;
            read_strobe_n_o <= conv ? !xfer_d
                                    : !(xfer_d && !dir_wr_q);
            read_strobe_oe_n <= !strobe_drv;
            high_byte_enable_n <= !(xfer_d && hi_used);
            high_byte_enable_oe_n <= !strobe_drv;
            bus_interrupt_oe_n <= !(role && ctrl_q.cfg_src
                                    && !ctrl_q.cfg_mask);
            bus_request_out <= conv ? !req_q : req_q;
            bus_request_oe_n <= !(bridge && ctrl_q.arb_en);
            grant_acknowledge_out_n <= !gack_q;
            grant_acknowledge_oe_n <= !bridge;
            bridge_clock_out <= !ph_q && !ctrl_q.clk_dis;
            bridge_clock_oe_n <= !(bridge && !ctrl_q.clk_dis);
            host_interrupt_a_n <= !(bus_interrupt_q && !ctrl_q.bus_interrupt_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [5:0] hold_rises_q;

    always_ff @(posedge clk) begin
        if (rst || !gack_q) begin
            hold_rises_q <= 6'h0;
        end else if (bridge_clock_out_rise && hold_rises_q != 6'h3f) begin
            hold_rises_q <= hold_rises_q + 6'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence grant_seen_s;
        bridge_clock_out_rise && state_q == ST_REQ && grant_act;
    endsequence

    sequence owning_s;
        gack_q && state_q == ST_XFER;
    endsequence

    addr_float_a: assert property (ce |=>
        local_address_bus_oe_n == !$past(xfer_d))
        else $error("address drive does not follow transfer");
    cfg_data_drive_a: assert property (ce && role && !cfg_rd |=>
        local_data_bus_oe_n)
        else $error("data driven outside host read");
    cfg_irq_pull_a: assert property (
        ce && role && ctrl_q.cfg_src && !ctrl_q.cfg_mask
        |=> !bus_interrupt_oe_n)
        else $error("interrupt line not pulled low");
    req_with_ack_a: assert property (
        (gack_q |-> req_q) and ($fell(gack_q) |-> $fell(req_q)))
        else $error("request and acknowledge out of step");
    ack_hold_a: assert property ($fell(gack_q) |->
        hold_rises_q >= `ARB_HOLD_MIN)
        else $error("grant acknowledge released early");
    grant_take_a: assert property (grant_seen_s |=> owning_s)
        else $error("grant not acknowledged");
    edge_step_a: assert property (state_q != $past(state_q) |->
        $past(bridge_clock_out_rise))
        else $error("sequencer moved off a bridge clock rise");
    host_irq_a: assert property (
        ce && bus_interrupt_q && !ctrl_q.bus_interrupt_mask |=> !host_interrupt_a_n)
        else $error("local interrupt not forwarded");
    high_lane_a: assert property (ce && xfer_d && !hi_used |=>
        high_byte_enable_n)
        else $error("high byte enable set on low lane transfer");
    done_ready_a: assert property ($rose(done_q) |->
        $past(state_q == ST_XFER && !pin_s2_q.rdy_n))
        else $error("completion without ready");
    cfg_commit_a: assert property (cfg_commit |->
        $past(cfg_sel, 2))
        else $error("write taken without chip select");

endmodule

`default_nettype wire

/* File: design/lbus_regs.svh */
`ifndef LBUS_REGS_SVH
`define LBUS_REGS_SVH

// Register byte offsets on the Wishbone bus.
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_XADDR 8'h08
`define OFF_XDATA 8'h0c
`define OFF_XCMD 8'h10
// Address bit that selects the shared word window.
`define MEM_WIN_BIT 6
// Reset values.
`define CTRL_RESET 11'h301
`define XCMD_RESET 4'h0
// Field positions.
`define STATUS_DONE_BIT 3
`define XCMD_WRITE_BIT 0
`define XCMD_BE_LSB 4
`define XCMD_BE_MSB 7
// Arbitration hold is 32 << timer bridge clocks.
`define ARB_BASE_LOG2 5'h05
`define ARB_HOLD_MIN 6'h20
// Address lines decoded in configuration mode.
`define CFG_DECODE_W 16

`endif

/* File: design/lbus_pkg.sv */
package lbus_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_REQ = 4'b0010,
        ST_XFER = 4'b0100,
        ST_HOLD = 4'b1000
    } bridge_state_t;

    typedef struct packed {
        logic role;
        logic conv;
        logic cs_n;
        logic rd_n;
        logic wr;
        logic rdy_n;
        logic grant;
        logic int_n;
        logic [19:0] addr;
        logic [15:0] data;
    } pin_in_t;

    typedef struct packed {
        logic cfg_src;
        logic cfg_mask;
        logic bus_interrupt_mask;
        logic [3:0] arb_timer;
        logic spare;
        logic clk_dis;
        logic arb_en;
        logic width16;
    } ctrl_t;

    typedef struct packed {
        logic [25:0] pad;
        logic grant_ack;
        logic bus_interrupt;
        logic done;
        logic busy;
        logic conv;
        logic role;
    } status_t;

endpackage

/* File: verif/local_bus_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module local_bus_partner
    import lbus_pkg::*;
(
    // System and settings.
    input wire logic clk,
    input wire logic strobe_convention_select,
    input wire logic [3:0] pm_delay,
    input wire logic [15:0] pm_rdata,
    // Pins driven by the bridge.
    input wire logic [19:0] local_address_bus_o,
    input wire logic local_address_bus_oe_n,
    input wire logic [15:0] local_data_bus_o,
    input wire logic local_data_bus_oe_n,
    input wire logic write_strobe_o,
    input wire logic read_strobe_n_o,
    input wire logic high_byte_enable_n,
    input wire logic bus_request_out,
    input wire logic bus_request_oe_n,
    // Pins driven by the peripheral and the arbiter.
    output logic [15:0] pm_data,
    output logic bridge_ready_in_n,
    output logic bus_grant_in,
    // What the peripheral saw on its last access.
    output logic [19:0] cap_addr,
    output logic [15:0] cap_data,
    output logic cap_hbe_n
);
    logic conv, strobe, act, rd_acc;
    logic [15:0] prev_q = 16'h0;
    logic [3:0] cnt_q = 4'h0;
    logic grant_q = 1'h0;

    assign conv = strobe_convention_select;
    assign strobe = !read_strobe_n_o || (!conv && !write_strobe_o);
    assign act = !local_address_bus_oe_n && strobe;
    assign rd_acc = act && write_strobe_o;
    // A released line toggles, so a stale value never passes for read data.
    assign pm_data = !local_data_bus_oe_n ? local_data_bus_o :
        (rd_acc ? pm_rdata : ~prev_q);
    assign bus_grant_in = conv ? !grant_q : grant_q;

    always @(posedge clk) begin
        prev_q <= pm_data;
        grant_q <= !bus_request_oe_n && (bus_request_out != conv);
        if (act) begin
            if (cnt_q != pm_delay)
                cnt_q <= cnt_q + 4'h1;
            else
                bridge_ready_in_n <= 1'h0;
            cap_addr <= local_address_bus_o;
            cap_hbe_n <= high_byte_enable_n;
        end else begin
            cnt_q <= 4'h0;
            bridge_ready_in_n <= 1'h1;
        end
        if (act && !write_strobe_o)
            cap_data <= local_data_bus_o;
    end
endmodule

`default_nettype wire

/* File: verif/local_bus_bridge_config_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lbus_regs.svh"

module local_bus_bridge_config_port_bench import lbus_pkg::*;;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic bus_role_select = 1'h0;
    logic strobe_convention_select = 1'h0;
    logic [15:0] local_data_bus_i, local_data_bus_o, pm_data, cap_data;
    logic [15:0] h_data = 16'h0;
    logic [15:0] pm_rdata = 16'hbeef;
    logic [19:0] local_address_bus_i = 20'h0;
    logic [19:0] local_address_bus_o, cap_addr;
    logic write_strobe_i = 1'h1;
    logic read_strobe_n_i = 1'h1;
    logic host_chip_select_n = 1'h1;
    logic bus_interrupt_n = 1'h1;
    logic [3:0] pm_delay = 4'h2;
    logic local_data_bus_oe_n, local_address_bus_oe_n, write_strobe_o;
    logic write_strobe_oe_n, read_strobe_n_o, read_strobe_oe_n;
    logic high_byte_enable_n, high_byte_enable_oe_n, bus_interrupt_n_i;
    logic bus_interrupt_n_o, bus_interrupt_oe_n, bridge_ready_in_n;
    logic bus_grant_in, bus_request_out, bus_request_oe_n, cap_hbe_n;
    logic grant_acknowledge_out_n, grant_acknowledge_oe_n;
    logic bridge_clock_out, bridge_clock_oe_n, host_interrupt_a_n;
    int err_count = 0;
    int num_checks = 0;
    int gack_len = 0;
    int gack_last = 0;

    assign local_data_bus_i = (bus_role_select && local_data_bus_oe_n) ?
        h_data : pm_data;
    assign bus_interrupt_n_i = bus_interrupt_n & (bus_interrupt_oe_n | bus_interrupt_n_o);

    local_bus_bridge_config_port u_local_bus_bridge_config_port (.*);

    local_bus_partner u_local_bus_partner (
        .clk, .strobe_convention_select, .pm_delay, .pm_rdata,
        .local_address_bus_o, .local_address_bus_oe_n, .local_data_bus_o,
        .local_data_bus_oe_n, .write_strobe_o, .read_strobe_n_o,
        .high_byte_enable_n, .bus_request_out, .bus_request_oe_n, .pm_data,
        .bridge_ready_in_n, .bus_grant_in, .cap_addr, .cap_data, .cap_hbe_n
    );

    ////////////////////////////////////////////////////////////////////////

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict;
        if (err_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wb(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1) begin
            err_count++;
            print_verdict;
        end
        @(posedge clk);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'h1, d, q);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'h0, 32'h0, q);
        chk(q, e);
    endtask

    task poll(input int b, input logic v);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wb(`OFF_STATUS, 1'h0, 32'h0, q);
            n++;
        end while (q[b] !== v && n < 300);
        if (q[b] !== v) begin
            err_count++;
            print_verdict;
        end
    endtask

    task do_reset(input logic role, input logic conv);
        bus_role_select <= role;
        strobe_convention_select <= conv;
        rst <= 1'h1;
        cyc(5);
        rst <= 1'h0;
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////////

    // One bridge transfer with the expected lanes worked out from the enables.
    task lane(input logic w, input logic [31:0] c, input logic [3:0] be);
        logic hi, lo;
        logic [15:0] m, d;
        logic [19:0] a;
        hi = c[0] & (~be[1] | ~be[3]);
        lo = ~be[0] | ~be[2] | ~hi;
        m = {{8{hi}}, {8{lo}}};
        d = {4{be}} ^ 16'h5a3c;
        a = {15'h4d2e, w, be};
        wr(`OFF_CTRL, c);
        poll(2, 1'h0);
        wr(`OFF_XADDR, {12'h0, a});
        wr(`OFF_XDATA, {16'h0, d});
        wr(`OFF_XCMD, {24'h0, be, 3'h0, w});
        poll(3, 1'h1);
        wr(`OFF_STATUS, 32'h8);
        chk(cap_addr, a);
        chk(cap_hbe_n, !hi);
        if (w)
            chk(cap_data & m, d & m);
        else
            rdc(`OFF_XDATA, {16'h0, pm_rdata & m});
    endtask

    task arb(input logic w, input logic [3:0] be);
        lane(w, 32'h303, be);
        poll(5, 1'h0);
        chk(gack_last >= 64 && gack_last <= 68, 1'h1);
    endtask

    task host(input logic w, input logic cs, input logic [19:0] a,
              input logic [15:0] d);
        host_chip_select_n <= cs;
        local_address_bus_i <= a;
        h_data <= d;
        write_strobe_i <= ~w;
        read_strobe_n_i <= w;
        cyc(6);
        chk(local_data_bus_oe_n, w | cs);
        if (!w && !cs)
            chk(local_data_bus_o, d);
        write_strobe_i <= 1'h1;
        read_strobe_n_i <= 1'h1;
        cyc(5);
        chk(local_data_bus_oe_n, 1'h1);
        host_chip_select_n <= 1'h1;
        h_data <= ~d;
        cyc(1);
    endtask

    task irq(input logic [31:0] c, input logic e);
        wr(`OFF_CTRL, c);
        cyc(4);
        chk(bus_interrupt_n_i, e);
    endtask

    // Length of each grant acknowledge, in system clocks.
    always @(posedge clk) begin
        if (!grant_acknowledge_out_n && !grant_acknowledge_oe_n) begin
            gack_len <= gack_len + 1;
        end else if (gack_len != 0) begin
            gack_last <= gack_len;
            gack_len <= 0;
            chk(!bus_request_oe_n && bus_request_out != strobe_convention_select,
                1'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////

    initial begin
        logic b;
        do_reset(1'h0, 1'h0);
        rdc(`OFF_CTRL, 32'h301);
        rdc(`OFF_STATUS, 32'h0);
        rdc(8'h20, 32'h0);
        chk({local_address_bus_oe_n, write_strobe_oe_n, read_strobe_oe_n,
             high_byte_enable_oe_n, bridge_clock_oe_n}, 5'h10);
        b = bridge_clock_out;
        cyc(1);
        chk(bridge_clock_out, !b);
        lane(1'h1, 32'h301, 4'h0);
        lane(1'h1, 32'h301, 4'he);
        lane(1'h1, 32'h301, 4'hd);
        lane(1'h1, 32'h300, 4'h0);
        lane(1'h1, 32'h301, 4'hf);
        pm_delay <= 4'hb;
        lane(1'h0, 32'h301, 4'h0);
        lane(1'h0, 32'h301, 4'hb);
        lane(1'h0, 32'h300, 4'h5);
        pm_delay <= 4'h1;
        wr(`OFF_CTRL, 32'h303);
        cyc(4);
        chk({write_strobe_oe_n, read_strobe_oe_n, high_byte_enable_oe_n},
            3'h7);
        arb(1'h1, 4'h0);
        bus_interrupt_n <= 1'h0;
        cyc(8);
        chk(host_interrupt_a_n, 1'h1);
        wr(`OFF_CTRL, 32'h203);
        cyc(8);
        chk(host_interrupt_a_n, 1'h0);
        bus_interrupt_n <= 1'h1;
        cyc(8);
        chk(host_interrupt_a_n, 1'h1);
        wr(`OFF_CTRL, 32'h207);
        cyc(4);
        chk(bridge_clock_oe_n, 1'h1);
        do_reset(1'h0, 1'h1);
        rdc(`OFF_STATUS, 32'h2);
        arb(1'h1, 4'h0);
        arb(1'h0, 4'hc);
        do_reset(1'h1, 1'h0);
        rdc(`OFF_STATUS, 32'h1);
        chk({bridge_clock_oe_n, bus_request_oe_n, grant_acknowledge_oe_n,
             local_address_bus_oe_n}, 4'hf);
        host(1'h1, 1'h0, 20'h00003, 16'h1234);
        host(1'h1, 1'h1, 20'h00003, 16'hdead);
        host(1'h1, 1'h0, 20'hf0005, 16'h5678);
        host(1'h0, 1'h0, 20'h00003, 16'h1234);
        host(1'h0, 1'h1, 20'h00003, 16'h1234);
        host(1'h0, 1'h0, 20'h50005, 16'h5678);
        rdc(8'h4c, 32'h1234);
        rdc(8'h54, 32'h5678);
        irq(32'h401, 1'h0);
        irq(32'h601, 1'h1);
        irq(32'h401, 1'h0);
        irq(32'h001, 1'h1);
        print_verdict;
    end
endmodule

`default_nettype wire
